// ### verilog/shutdown_pkg.sv
package shutdown_pkg;

    // Register bus shape
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_LIVE = 3'h4;

    // Control register fields
    localparam int FLAG_BIT = 7;
    localparam int SEL_LSB = 4;
    localparam int SEL_W = 3;
    localparam int PIN_A_LSB = 2;
    localparam int PIN_B_LSB = 0;
    localparam int PIN_W = 2;
    localparam int TRI_BIT = 1;

    // Interrupt status fields
    localparam int INT_W = 2;
    localparam int INT_ENTER_BIT = 0;
    localparam int INT_EXIT_BIT = 1;

    // Values after reset
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam logic [PIN_W-1:0] PIN_RST = 2'h0;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
    localparam logic [1:0] SYNC_RST = 2'h3;

    // Shutdown source codes
    localparam logic [SEL_W-1:0] SRC_OFF = 3'h0;
    localparam logic [SEL_W-1:0] SRC_CMP = 3'h1;
    localparam logic [SEL_W-1:0] SRC_RSVD_A = 3'h2;
    localparam logic [SEL_W-1:0] SRC_CMP_ANY = 3'h3;
    localparam logic [SEL_W-1:0] SRC_FLT = 3'h4;
    localparam logic [SEL_W-1:0] SRC_EITHER = 3'h5;
    localparam logic [SEL_W-1:0] SRC_RSVD_B = 3'h6;
    localparam logic [SEL_W-1:0] SRC_EITHER_ALT = 3'h7;

    // Pin shutdown state codes
    localparam logic [PIN_W-1:0] PIN_DRIVE_LOW = 2'h0;
    localparam logic [PIN_W-1:0] PIN_DRIVE_HIGH = 2'h1;

    typedef enum logic {
        ST_RUN,
        ST_SHUT
    } sd_state_t;

endpackage

// ### verilog/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// ### verilog/pwm_auto_shutdown_ctrl.sv
`timescale 1ns/1ps
module pwm_auto_shutdown_ctrl
    import shutdown_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic fault_input_pin_i,
    input wire logic analog_comparator_one_i,
    input wire logic pwm_a_i,
    input wire logic pwm_b_i,
    output logic pwm_out_a_o,
    output logic pwm_out_a_oe_o,
    output logic pwm_out_b_o,
    output logic pwm_out_b_oe_o,
    output logic shutdown_event_flag_o,
    output logic irq_o
);

    logic [1:0] pins_s;
    logic flt_s;
    logic cmp_s;

    // Pin inputs idle high so reset shows no fault
    sync_2ff #(
        .WIDTH(2),
        .RESET_VAL(SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({fault_input_pin_i, analog_comparator_one_i}),
        .sync_o(pins_s)
    );

    assign flt_s = pins_s[1];
    assign cmp_s = pins_s[0];

    logic ctrl_wr;
    logic clr_wr;
    logic en_wr;

    assign ctrl_wr = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    assign clr_wr = reg_wr_i && (reg_addr_i == ADDR_INT_CLEAR);
    assign en_wr = reg_wr_i && (reg_addr_i == ADDR_INT_ENABLE);

    // Configuration fields
    logic [SEL_W-1:0] sel_q, sel_d;
    logic [PIN_W-1:0] pin_a_shutdown_state_q, pin_a_shutdown_state_d;
    logic [PIN_W-1:0] pin_b_shutdown_state_q, pin_b_shutdown_state_d;

    always_comb begin
        sel_d = sel_q;
        pin_a_shutdown_state_d = pin_a_shutdown_state_q;
        pin_b_shutdown_state_d = pin_b_shutdown_state_q;
        if (ctrl_wr) begin
            sel_d = reg_wdata_i[SEL_LSB +: SEL_W];
            pin_a_shutdown_state_d = reg_wdata_i[PIN_A_LSB +: PIN_W];
            pin_b_shutdown_state_d = reg_wdata_i[PIN_B_LSB +: PIN_W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_q <= SEL_RST;
            pin_a_shutdown_state_q <= PIN_RST;
            pin_b_shutdown_state_q <= PIN_RST;
        end else begin
            sel_q <= sel_d;
            pin_a_shutdown_state_q <= pin_a_shutdown_state_d;
            pin_b_shutdown_state_q <= pin_b_shutdown_state_d;
        end
    end

    // Fault source selection
    logic trip;

    always_comb begin
        trip = 1'b0;
        case (sel_q)
            SRC_OFF: trip = 1'b0;
            SRC_CMP: trip = !cmp_s;
            SRC_CMP_ANY: trip = !cmp_s;
            SRC_FLT: trip = !flt_s;
            SRC_EITHER: trip = !flt_s || !cmp_s;
            SRC_EITHER_ALT: trip = !flt_s || !cmp_s;
            default: trip = 1'b0;
        endcase
    end

    // Shutdown state; a trip beats a software clear
    sd_state_t state_q, state_d;
    logic shutdown_flag_q, shutdown_flag_d;
    logic enter_ev;
    logic exit_ev;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (trip || (ctrl_wr && reg_wdata_i[FLAG_BIT])) begin
                    state_d = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (ctrl_wr && !reg_wdata_i[FLAG_BIT] && !trip) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
        shutdown_flag_d = (state_d == ST_SHUT);
        enter_ev = (state_q == ST_RUN) && (state_d == ST_SHUT);
        exit_ev = (state_q == ST_SHUT) && (state_d == ST_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_RUN;
            shutdown_flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shutdown_flag_q <= shutdown_flag_d;
        end
    end

    assign shutdown_event_flag_o = shutdown_flag_q;

    // Output override
    logic out_a_q, out_a_d, oe_a_q, oe_a_d;
    logic out_b_q, out_b_d, oe_b_q, oe_b_d;

    always_comb begin
        out_a_d = pwm_a_i;
        oe_a_d = 1'b1;
        out_b_d = pwm_b_i;
        oe_b_d = 1'b1;
        if (state_q == ST_SHUT) begin
            if (pin_a_shutdown_state_q[TRI_BIT]) begin
                oe_a_d = 1'b0;
                out_a_d = 1'b0;
            end else if (pin_a_shutdown_state_q == PIN_DRIVE_HIGH) begin
                out_a_d = 1'b1;
            end else begin
                out_a_d = 1'b0;
            end
            if (pin_b_shutdown_state_q[TRI_BIT]) begin
                oe_b_d = 1'b0;
                out_b_d = 1'b0;
            end else if (pin_b_shutdown_state_q == PIN_DRIVE_HIGH) begin
                out_b_d = 1'b1;
            end else begin
                out_b_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_a_q <= 1'b0;
            oe_a_q <= 1'b0;
            out_b_q <= 1'b0;
            oe_b_q <= 1'b0;
        end else begin
            out_a_q <= out_a_d;
            oe_a_q <= oe_a_d;
            out_b_q <= out_b_d;
            oe_b_q <= oe_b_d;
        end
    end

    assign pwm_out_a_o = out_a_q;
    assign pwm_out_a_oe_o = oe_a_q;
    assign pwm_out_b_o = out_b_q;
    assign pwm_out_b_oe_o = oe_b_q;

    // Interrupt status, enable and line; set wins over clear
    logic [INT_W-1:0] int_stat_q, int_stat_d;
    logic [INT_W-1:0] int_en_q, int_en_d;
    logic irq_q, irq_d;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;

    always_comb begin
        int_set = '0;
        int_set[INT_ENTER_BIT] = enter_ev;
        int_set[INT_EXIT_BIT] = exit_ev;
        int_clr = clr_wr ? reg_wdata_i[INT_W-1:0] : '0;
        int_stat_d = (int_stat_q & ~int_clr) | int_set;
        int_en_d = en_wr ? reg_wdata_i[INT_W-1:0] : int_en_q;
        irq_d = |(int_stat_q & int_en_q);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            int_stat_q <= INT_RST;
            int_en_q <= INT_RST;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            int_en_q <= int_en_d;
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

    // Read data, valid only in the cycle after the strobe
    logic [DATA_W-1:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = RDATA_RST;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CTRL: rdata_d = {shutdown_flag_q, sel_q,
                    pin_a_shutdown_state_q, pin_b_shutdown_state_q};
                ADDR_INT_STATUS: rdata_d = {6'h00, int_stat_q};
                ADDR_INT_ENABLE: rdata_d = {6'h00, int_en_q};
                ADDR_LIVE: rdata_d = {5'h00, trip, flt_s, cmp_s};
                default: rdata_d = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // Checks
    logic no_ctrl_wr;
    assign no_ctrl_wr = !ctrl_wr;

    disabled_quiet_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (sel_q == SRC_OFF) && (state_q == ST_RUN) && no_ctrl_wr
        |=> !shutdown_event_flag_o)
        else $error("shutdown entered with source disabled");

    cmp_trip_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (sel_q == SRC_CMP) && !cmp_s |=> shutdown_event_flag_o)
        else $error("comparator low did not trip code one");

    cmp_any_trip_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (sel_q == SRC_CMP_ANY) && !cmp_s
        |=> shutdown_event_flag_o && (state_q == ST_SHUT))
        else $error("comparator low did not trip code three");

    pin_to_flag_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (sel_q == SRC_FLT) && $stable(sel_q) && !fault_input_pin_i
        ##2 ((sel_q == SRC_FLT) && no_ctrl_wr)
        |=> shutdown_event_flag_o)
        else $error("fault pin low did not trip code four");

    either_trip_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ((sel_q == SRC_EITHER) || (sel_q == SRC_EITHER_ALT))
        && (!flt_s || !cmp_s) |=> shutdown_event_flag_o)
        else $error("either source did not trip");

    a_tristate_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && pin_a_shutdown_state_q[TRI_BIT]
        |=> !pwm_out_a_oe_o)
        else $error("pin a not released in shutdown");

    a_high_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && (pin_a_shutdown_state_q == PIN_DRIVE_HIGH)
        |=> pwm_out_a_oe_o && pwm_out_a_o)
        else $error("pin a not driven high in shutdown");

    a_low_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && (pin_a_shutdown_state_q == PIN_DRIVE_LOW)
        |=> pwm_out_a_oe_o && !pwm_out_a_o)
        else $error("pin a not driven low in shutdown");

    b_tristate_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && pin_b_shutdown_state_q[TRI_BIT]
        |=> !pwm_out_b_oe_o)
        else $error("pin b not released in shutdown");

    b_high_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && (pin_b_shutdown_state_q == PIN_DRIVE_HIGH)
        |=> pwm_out_b_oe_o && pwm_out_b_o)
        else $error("pin b not driven high in shutdown");

    b_low_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && (pin_b_shutdown_state_q == PIN_DRIVE_LOW)
        |=> pwm_out_b_oe_o && !pwm_out_b_o)
        else $error("pin b not driven low in shutdown");

    flag_hold_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && !(ctrl_wr && !reg_wdata_i[FLAG_BIT])
        |=> shutdown_event_flag_o && $rose(int_stat_q[INT_ENTER_BIT]) == 1'b0)
        else $error("shutdown flag dropped without a clear");

    reserved_quiet_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ((sel_q == SRC_RSVD_A) || (sel_q == SRC_RSVD_B))
        && (state_q == ST_RUN) && no_ctrl_wr |=> !shutdown_event_flag_o)
        else $error("reserved source code tripped");

    run_pass_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !shutdown_event_flag_o |=> pwm_out_a_oe_o && pwm_out_b_oe_o
        && (pwm_out_a_o == $past(pwm_a_i)) && (pwm_out_b_o == $past(pwm_b_i)))
        else $error("pwm not passed through while running");

    irq_line_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        enter_ev && int_en_q[INT_ENTER_BIT] && !en_wr |=> ##1 irq_o)
        else $error("enabled shutdown event gave no interrupt");

    trip_cover_c: cover property (@(posedge clk_i)
        disable iff (sys_rst_i) enter_ev && trip);

    release_cover_c: cover property (@(posedge clk_i)
        disable iff (sys_rst_i) exit_ev);

    clear_race_c: cover property (@(posedge clk_i)
        disable iff (sys_rst_i)
        shutdown_event_flag_o && ctrl_wr && !reg_wdata_i[FLAG_BIT] && trip);

    irq_cover_c: cover property (@(posedge clk_i)
        disable iff (sys_rst_i) $rose(irq_o));

endmodule

// ### verif/pin_side_model.sv
`timescale 1ns/1ps
module pin_side_model (
    input wire logic clk_i,
    input wire logic fault_req_i,
    input wire logic cmp_req_i,
    input wire logic out_a_i,
    input wire logic oe_a_i,
    input wire logic out_b_i,
    input wire logic oe_b_i,
    output logic fault_pin_o,
    output logic cmp_o,
    output logic pin_a_o,
    output logic pin_b_o
);
    logic last_a_q = 1'b0;
    logic last_b_q = 1'b0;

    // Fault sources are active low
    assign fault_pin_o = ~fault_req_i;
    assign cmp_o = ~cmp_req_i;

    // Remember last driven level of each pin
    always @(posedge clk_i) begin
        if (oe_a_i) begin
            last_a_q <= out_a_i;
        end
        if (oe_b_i) begin
            last_b_q <= out_b_i;
        end
    end

    // Released pin floats: show inverse of last driven level
    assign pin_a_o = oe_a_i ? out_a_i : ~last_a_q;
    assign pin_b_o = oe_b_i ? out_b_i : ~last_b_q;
endmodule

// ### verif/tb_pwm_auto_shutdown_ctrl.sv
`timescale 1ns/1ps
module tb_pwm_auto_shutdown_ctrl;
    import shutdown_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic fault_pin, cmp_out, pin_a, pin_b;
    logic pwm_a_i = 1'b0;
    logic pwm_b_i = 1'b1;
    logic out_a, oe_a, out_b, oe_b, flag, irq_o;
    logic fault_req = 1'b0;
    logic cmp_req = 1'b0;
    int fails = 0;
    int checks_done = 0;

    always #10 clk_i = ~clk_i;

    pwm_auto_shutdown_ctrl pwm_auto_shutdown_ctrl_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .fault_input_pin_i(fault_pin), .analog_comparator_one_i(cmp_out),
        .pwm_a_i(pwm_a_i), .pwm_b_i(pwm_b_i), .pwm_out_a_o(out_a),
        .pwm_out_a_oe_o(oe_a), .pwm_out_b_o(out_b), .pwm_out_b_oe_o(oe_b),
        .shutdown_event_flag_o(flag), .irq_o(irq_o)
    );

    pin_side_model pin_side_model_inst (
        .clk_i(clk_i), .fault_req_i(fault_req), .cmp_req_i(cmp_req),
        .out_a_i(out_a), .oe_a_i(oe_a), .out_b_i(out_b), .oe_b_i(oe_b),
        .fault_pin_o(fault_pin), .cmp_o(cmp_out),
        .pin_a_o(pin_a), .pin_b_o(pin_b)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(what, reg_rdata_o, exp);
    endtask

    // Pin state while shut down: 1x released, 01 high, 00 low
    task automatic chk_pins(input logic [1:0] pa, input logic [1:0] pb);
        check("oe_a", 8'(oe_a), 8'(!pa[1]));
        check("oe_b", 8'(oe_b), 8'(!pb[1]));
        if (!pa[1]) check("pin_a", 8'(pin_a), 8'(pa[0]));
        if (!pb[1]) check("pin_b", 8'(pin_b), 8'(pb[0]));
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        fails++;
        stop_test();
    end

    initial begin
        logic trip;
        repeat (11) @(posedge clk_i);
        #1;
        check("rst_out", 8'({out_a, oe_a, out_b, oe_b, flag, irq_o}), 8'h00);
        check("rst_rdata", reg_rdata_o, 8'h00);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cycles(3);
        chk_pins(2'h0, 2'h1);
        rd_chk("ctrl_rst", ADDR_CTRL, 8'h00);
        rd_chk("unmapped", 3'h5, 8'h00);
        reg_wr(ADDR_INT_ENABLE, 8'h01);
        for (int c = 0; c < 8; c++) begin
            if (c == 2 || c == 6) continue;
            for (int s = 0; s < 2; s++) begin
                reg_wr(ADDR_CTRL, {1'b0, 3'(c), PIN_DRIVE_HIGH, PIN_DRIVE_LOW});
                if (s == 0) fault_req <= 1'b1;
                else cmp_req <= 1'b1;
                trip = (s == 0) ? c[2] : c[0];
                cycles(6);
                check("flag", 8'(flag), 8'(trip));
                check("irq", 8'(irq_o), 8'(trip));
                if (trip) chk_pins(2'h1, 2'h0);
                rd_chk("live", ADDR_LIVE,
                       {5'h00, trip, 1'(s), 1'(1 - s)});
                // Release request while the fault persists
                reg_wr(ADDR_CTRL, {1'b0, 3'(c), 4'h0});
                cycles(3);
                check("held", 8'(flag), 8'(trip));
                if (trip) chk_pins(2'h0, 2'h0);
                fault_req <= 1'b0;
                cmp_req <= 1'b0;
                cycles(4);
                reg_wr(ADDR_CTRL, 8'h00);
                cycles(3);
                check("release", 8'(flag), 8'h00);
                chk_pins(2'h0, 2'h1);
                rd_chk("status", ADDR_INT_STATUS, trip ? 8'h03 : 8'h00);
                reg_wr(ADDR_INT_CLEAR, 8'h03);
                cycles(3);
                check("irq_clr", 8'(irq_o), 8'h00);
            end
        end
        // Every shutdown state on both pins
        for (int i = 0; i < 4; i++) begin
            // PWM inputs opposite to the forced levels
            pwm_a_i <= !i[0];
            pwm_b_i <= i[0];
            reg_wr(ADDR_CTRL, {1'b1, SRC_OFF, 2'(i), 2'(3 - i)});
            cycles(3);
            chk_pins(2'(i), 2'(3 - i));
        end
        // Masked then enabled interrupt
        pwm_a_i <= 1'b0;
        pwm_b_i <= 1'b1;
        reg_wr(ADDR_INT_ENABLE, 8'h00);
        cycles(3);
        check("irq_mask", 8'(irq_o), 8'h00);
        rd_chk("status_m", ADDR_INT_STATUS, 8'h01);
        reg_wr(ADDR_INT_CLEAR, 8'h03);
        rd_chk("status_c", ADDR_INT_STATUS, 8'h00);
        reg_wr(ADDR_INT_ENABLE, 8'h02);
        reg_wr(ADDR_CTRL, 8'h00);
        cycles(3);
        check("irq_exit", 8'(irq_o), 8'h01);
        rd_chk("status_x", ADDR_INT_STATUS, 8'h02);
        rd_chk("enable", ADDR_INT_ENABLE, 8'h02);
        reg_wr(ADDR_INT_CLEAR, 8'h02);
        cycles(3);
        check("irq_off", 8'(irq_o), 8'h00);
        chk_pins(2'h0, 2'h1);
        // Reset in mid-run while shut down
        reg_wr(ADDR_CTRL, 8'h80);
        cycles(3);
        check("forced", 8'(flag), 8'h01);
        sys_rst_i <= 1'b1;
        cycles(3);
        check("rst_mid", 8'({out_a, oe_a, out_b, oe_b, flag, irq_o}), 8'h00);
        sys_rst_i <= 1'b0;
        cycles(2);
        chk_pins(2'h0, 2'h1);
        rd_chk("ctrl_mid", ADDR_CTRL, 8'h00);
        rd_chk("enable_mid", ADDR_INT_ENABLE, 8'h00);
        stop_test();
    end
endmodule
